// ===== design/unicor_cfg.svh
// constants of the node address, pin level, position compare and otp register group
// Notes on behaviour
// R01: eight-bit node address picks answered frames
// R02: address pin active adds one to address
// R03: address 0..253, reset zero, 254 not incremented; the code still adds one to 254, giving 255
// R04: reply delay codes 2n,2n+1 give (2n+1)*8 bits
// R05: host avoids delay codes 0,1 on shared bus
// R06: pin levels read live in bits 5..0
// R07: bit 6 shows external step source mode
// R08: bit 7 shows switch node comparator output
// R09: bits 31..24 hold fixed version code
// R10: polarity bit drives serial out pin level
// R11: polarity bit resets to one
// R12: 32-bit compare value, pulse on diag pin
// R13: pulse high while position equals compare value
// R14: each unlocked write programs one memory bit
// R15: read of program register reloads read data
// R16: bits 2..0 pick bit, 5..4 pick byte
// R17: program only with unlock key, 10 ms per bit
// R18: comparison evaluated on every clock cycle
`ifndef UNICOR_CFG_SVH
`define UNICOR_CFG_SVH

// ==========================================================
// register indices
`define UNICOR_ADDR_W 7
`define UNICOR_REG_UNIT_CFG 7'h03
`define UNICOR_REG_PIN_LEVELS 7'h04
`define UNICOR_REG_OUT_POLARITY 7'h04
`define UNICOR_REG_MATCH_VALUE 7'h05
`define UNICOR_REG_OTP_BIT_PROGRAM 7'h06
`define UNICOR_REG_OTP_READ 7'h07

// ==========================================================
// field layouts
`define UNICOR_NODE_MSB 7
`define UNICOR_NODE_LSB 0
`define UNICOR_DELAY_MSB 11
`define UNICOR_DELAY_LSB 8
`define UNICOR_POL_BIT 0
`define UNICOR_VERSION_MSB 31
`define UNICOR_VERSION_LSB 24
`define UNICOR_OTP_BIT_MSB 2
`define UNICOR_OTP_BIT_LSB 0
`define UNICOR_OTP_BYTE_MSB 5
`define UNICOR_OTP_BYTE_LSB 4
`define UNICOR_OTP_KEY_MSB 15
`define UNICOR_OTP_KEY_LSB 8
`define UNICOR_PIN_FIELD_W 16

// ==========================================================
// values
`define UNICOR_OTP_KEY 8'hbd
`define UNICOR_NODE_RESET 8'h00
`define UNICOR_DELAY_RESET 4'h0
`define UNICOR_POL_RESET 1'h1
`define UNICOR_OTP_BYTES 4
`define UNICOR_DELAY_W 7
`define UNICOR_CNT_W 20

// ==========================================================
// timing
`define UNICOR_CLK_KHZ 25000
`define UNICOR_OTP_BIT_PROGRAM_TIME_MS 10
`define UNICOR_OTP_BIT_PROGRAM_CYCLES (`UNICOR_OTP_BIT_PROGRAM_TIME_MS * `UNICOR_CLK_KHZ)

`endif

// ===== design/unicor_otp_cells.sv
// one-time memory cell array, set one bit per burn strobe
`timescale 1ns/1ps
`include "unicor_cfg.svh"
module unicor_otp_cells (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic prog_fire,
  input wire logic [1:0] prog_byte,
  input wire logic [2:0] prog_bit,
  output logic [31:0] cells
);

  // ==========================================================
  // state
  unicor_pkg::unicor_cells_t cur_r; // registered cells
  unicor_pkg::unicor_cells_t cur_nxt; // next cells
  // a net, since every cell bit has its own generated driver
  wire logic [`UNICOR_OTP_BYTES-1:0][7:0] set_vec; // cells hit this cycle

  // ==========================================================
  // per-cell set decode
  genvar gb;
  genvar gi;
  generate
    for (gb = 0; gb < `UNICOR_OTP_BYTES; gb++) begin : g_byte
      for (gi = 0; gi < 8; gi++) begin : g_bit
        // fuse only ever goes to one, never back
        assign set_vec[gb][gi] = prog_fire && (prog_byte == 2'(gb)) && (prog_bit == 3'(gi)); // R16
      end
    end
  endgenerate

  // next value: sticky or of the hit cell
  always_comb begin
    cur_nxt = cur_r;
    cur_nxt.cells_r = cur_r.cells_r | set_vec; // R14
  end

  // register; reset stands in for unfused silicon
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cur_r <= '0;
    end else begin
      cur_r <= cur_nxt;
    end
  end

  assign cells = cur_r.cells_r;

endmodule : unicor_otp_cells

// ===== design/unicor_pkg.sv
// types of the node address, pin level, position compare and otp register group
`include "unicor_cfg.svh"
package unicor_pkg;

  // ==========================================================
  // otp programming sequencer
  typedef enum logic [0:0] {
    UNICOR_OTP_IDLE,
    UNICOR_OTP_BURN
  } unicor_otp_state_t;

  // ==========================================================
  // whole state of the register group
  typedef struct packed {
    logic [7:0] node_address_r;          // programmed node address
    logic [3:0] reply_delay_r;           // reply delay code
    logic polarity_r;                    // serial out pin polarity
    logic [31:0] match_value_r;          // position compare value
    logic pulse_r;                       // position pulse
    logic [7:0] node_eff_r;              // address after increment
    logic [`UNICOR_DELAY_W-1:0] delay_bits_r; // reply delay in bit times
    logic [31:0] rdata_r;                // read answer
    logic rvalid_r;                      // read answer strobe
    logic [31:0] otp_read_r;             // latched otp read data
    unicor_otp_state_t otp_state;        // sequencer state
    logic [`UNICOR_CNT_W-1:0] otp_count_r; // burn time left
    logic [1:0] prog_byte_r;             // byte being burnt
    logic [2:0] prog_bit_r;              // bit being burnt
    logic prog_fire_r;                   // one-cycle burn strobe
    logic sdo_level_r;                   // serial out pin level
    logic sdo_oe_r;                      // serial out pin enable
  } unicor_state_t;

  // ==========================================================
  // otp cell array state
  typedef struct packed {
    logic [`UNICOR_OTP_BYTES-1:0][7:0] cells_r; // fused bits
  } unicor_cells_t;

endpackage : unicor_pkg

// ===== design/unicor_regs.sv
// general configuration register group: node address, pin levels, polarity, compare, otp
`timescale 1ns/1ps
`include "unicor_cfg.svh"
module unicor_regs #(
  // burn time per bit in cycles; shorten in simulation
  parameter int unsigned OTP_BIT_PROGRAM_CYCLES = `UNICOR_OTP_BIT_PROGRAM_CYCLES,
  // arbitrary version code, no meaning
  parameter logic [7:0] VERSION_CODE = 8'h5a
) (
  input wire logic ref_clk,
  input wire logic rst,
  // register access from the serial interface
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [`UNICOR_ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  output logic reg_rvalid,
  // input pins
  input wire logic left_ref_step_input,
  input wire logic right_ref_direction_input,
  input wire logic encoder_b_config_pin,
  input wire logic encoder_a_config_pin,
  input wire logic driver_disable_pin,
  input wire logic encoder_index_config_pin,
  input wire logic step_source_select,
  input wire logic switch_node_comparator,
  input wire logic address_increment_pin,
  input wire logic uart_mode,
  // motion controller position
  input wire logic [31:0] actual_position,
  // derived configuration toward the uart
  output logic [7:0] node_address,
  output logic [`UNICOR_DELAY_W-1:0] reply_delay_bit_times,
  // pins driven
  output logic serial_out_config_pin,
  output logic serial_out_config_oe,
  output logic position_pulse_output_pin,
  // otp status
  output logic otp_busy,
  output logic [31:0] otp_read_data
);

  // ==========================================================
  // state and helper signals
  unicor_pkg::unicor_state_t st_r;   // registered state
  unicor_pkg::unicor_state_t st_nxt; // next state
  logic [31:0] otp_cells;            // fused bits from the array
  logic [`UNICOR_CNT_W-1:0] burn_load; // reload of burn counter
  logic key_ok;                      // unlock key present in write

  // counter width holds the full default burn time
  assign burn_load = `UNICOR_CNT_W'(OTP_BIT_PROGRAM_CYCLES - 1);

  // ==========================================================
  // decode functions

  // write strobe for one register index
  function automatic logic hit_wr(
    input logic wr,
    input logic [`UNICOR_ADDR_W-1:0] addr,
    input logic [`UNICOR_ADDR_W-1:0] idx
  );
    hit_wr = wr && (addr == idx);
  endfunction : hit_wr

  // reply delay: codes 2n and 2n+1 both give (2n+1)*8 bit times
  function automatic logic [`UNICOR_DELAY_W-1:0] delay_of(input logic [3:0] code);
    delay_of = {code[3:1], 1'b1, 3'h0}; // R04
  endfunction : delay_of

  // live pin levels packed as read back
  function automatic logic [31:0] pin_word(
    input logic [7:0] pins,
    input logic [7:0] ver
  );
    pin_word = '0;
    pin_word[7:0] = pins;
    pin_word[`UNICOR_VERSION_MSB:`UNICOR_VERSION_LSB] = ver; // R09
  endfunction : pin_word

  // ==========================================================
  // next-state logic
  always_comb begin
    st_nxt = st_r;
    key_ok = reg_wdata[`UNICOR_OTP_KEY_MSB:`UNICOR_OTP_KEY_LSB] == `UNICOR_OTP_KEY;

    // --- unit address configuration write
    if (hit_wr(reg_wr, reg_addr, `UNICOR_REG_UNIT_CFG)) begin
      st_nxt.node_address_r = reg_wdata[`UNICOR_NODE_MSB:`UNICOR_NODE_LSB]; // R01
      st_nxt.reply_delay_r = reg_wdata[`UNICOR_DELAY_MSB:`UNICOR_DELAY_LSB]; // R04
    end

    // --- output polarity write; shares its index with the pin read
    if (hit_wr(reg_wr, reg_addr, `UNICOR_REG_OUT_POLARITY)) begin
      st_nxt.polarity_r = reg_wdata[`UNICOR_POL_BIT]; // R10
    end

    // --- position compare value write
    if (hit_wr(reg_wr, reg_addr, `UNICOR_REG_MATCH_VALUE)) begin
      st_nxt.match_value_r = reg_wdata; // R12
    end

    // --- effective node address; the host keeps 254 out of use with the pin
    if (address_increment_pin) begin
      st_nxt.node_eff_r = st_r.node_address_r + 8'h01; // R02 R03
    end else begin
      st_nxt.node_eff_r = st_r.node_address_r; // R01
    end

    // --- reply delay in bit times for the transmitter
    st_nxt.delay_bits_r = delay_of(st_r.reply_delay_r); // R04

    // --- position pulse: compared each cycle, drops on first mismatch
    st_nxt.pulse_r = (actual_position == st_r.match_value_r); // R13 R18

    // --- serial out pin acts as chain output only in uart mode
    st_nxt.sdo_level_r = st_r.polarity_r; // R10
    st_nxt.sdo_oe_r = uart_mode;

    // --- read answer, one cycle after the strobe
    st_nxt.rvalid_r = reg_rd;
    if (reg_rd) begin
      unique case (reg_addr)
        `UNICOR_REG_PIN_LEVELS: begin
          // pins sampled at the strobe, so the value is live
          st_nxt.rdata_r = pin_word({switch_node_comparator, // R08
                                     step_source_select,     // R07
                                     encoder_index_config_pin,
                                     driver_disable_pin,
                                     encoder_a_config_pin,
                                     encoder_b_config_pin,
                                     right_ref_direction_input,
                                     left_ref_step_input}, VERSION_CODE); // R06
        end
        `UNICOR_REG_OTP_READ: begin
          // shows the data latched by the last refresh
          st_nxt.rdata_r = st_r.otp_read_r;
        end
        default: begin
          // write-only or unmapped indices read as zero
          st_nxt.rdata_r = '0;
        end
      endcase
    end else begin
      st_nxt.rdata_r = '0;
    end

    // --- read of the program register refreshes otp read data
    if (reg_rd && (reg_addr == `UNICOR_REG_OTP_BIT_PROGRAM)) begin
      st_nxt.otp_read_r = otp_cells; // R15
    end

    // --- otp burn sequencer
    st_nxt.prog_fire_r = 1'b0;
    unique case (st_r.otp_state)
      unicor_pkg::UNICOR_OTP_IDLE: begin
        // a write without the key is dropped silently
        if (hit_wr(reg_wr, reg_addr, `UNICOR_REG_OTP_BIT_PROGRAM) && key_ok) begin // R17
          st_nxt.prog_bit_r = reg_wdata[`UNICOR_OTP_BIT_MSB:`UNICOR_OTP_BIT_LSB]; // R16
          st_nxt.prog_byte_r = reg_wdata[`UNICOR_OTP_BYTE_MSB:`UNICOR_OTP_BYTE_LSB]; // R16
          st_nxt.otp_count_r = burn_load;
          st_nxt.otp_state = unicor_pkg::UNICOR_OTP_BURN;
        end
      end
      unicor_pkg::UNICOR_OTP_BURN: begin
        // writes during a burn are ignored: one bit per access
        if (st_r.otp_count_r == '0) begin
          st_nxt.prog_fire_r = 1'b1; // R14
          st_nxt.otp_state = unicor_pkg::UNICOR_OTP_IDLE;
        end else begin
          st_nxt.otp_count_r = st_r.otp_count_r - `UNICOR_CNT_W'(1); // R17
        end
      end
    endcase
  end

  // ==========================================================
  // state register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_r <= '0;
      st_r.node_address_r <= `UNICOR_NODE_RESET; // R03
      st_r.node_eff_r <= `UNICOR_NODE_RESET;
      st_r.reply_delay_r <= `UNICOR_DELAY_RESET;
      st_r.polarity_r <= `UNICOR_POL_RESET; // R11
      st_r.sdo_level_r <= `UNICOR_POL_RESET;
      st_r.otp_state <= unicor_pkg::UNICOR_OTP_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // otp cell array
  unicor_otp_cells u_cells (
    .ref_clk(ref_clk),
    .rst(rst),
    .prog_fire(st_r.prog_fire_r),
    .prog_byte(st_r.prog_byte_r),
    .prog_bit(st_r.prog_bit_r),
    .cells(otp_cells)
  );

  // ==========================================================
  // outputs, all straight from flip-flops
  assign reg_rdata = st_r.rdata_r;
  assign reg_rvalid = st_r.rvalid_r;
  assign node_address = st_r.node_eff_r;
  assign reply_delay_bit_times = st_r.delay_bits_r;
  assign serial_out_config_pin = st_r.sdo_level_r;
  assign serial_out_config_oe = st_r.sdo_oe_r;
  assign position_pulse_output_pin = st_r.pulse_r; // R12
  assign otp_busy = (st_r.otp_state == unicor_pkg::UNICOR_OTP_BURN);
  assign otp_read_data = st_r.otp_read_r;

endmodule : unicor_regs

// ===== tb/uart_node_io_compare_otp_regs_tb.sv
// bench of the register group with a host model
`timescale 1ns/1ps
`include "unicor_cfg.svh"
module uart_node_io_compare_otp_regs_tb;
  localparam int unsigned PROG = 4; // short burn time
  localparam logic [7:0] VER = 8'h5a; // arbitrary version code
  logic ref_clk, rst, reg_wr, reg_rd, reg_rvalid, address_increment_pin, uart_mode, ok;
  logic left_ref_step_input, right_ref_direction_input, encoder_b_config_pin, encoder_a_config_pin;
  logic driver_disable_pin, encoder_index_config_pin, step_source_select, switch_node_comparator;
  logic serial_out_config_pin, serial_out_config_oe, position_pulse_output_pin, otp_busy;
  logic [6:0] reg_addr, reply_delay_bit_times;
  logic [31:0] reg_wdata, reg_rdata, actual_position, otp_read_data, d, v, ex;
  logic [7:0] node_address, a, p;
  logic [3:0] c;
  logic [1:0] b;
  logic [2:0] n;
  int seed, num_errors, n_checks;
  unicor_regs #(.OTP_BIT_PROGRAM_CYCLES(PROG), .VERSION_CODE(VER)) i_unicor_regs (.ref_clk, .rst, .reg_wr, .reg_rd,
    .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid, .left_ref_step_input, .right_ref_direction_input,
    .encoder_b_config_pin, .encoder_a_config_pin, .driver_disable_pin, .encoder_index_config_pin,
    .step_source_select, .switch_node_comparator, .address_increment_pin, .uart_mode, .actual_position,
    .node_address, .reply_delay_bit_times, .serial_out_config_pin, .serial_out_config_oe,
    .position_pulse_output_pin, .otp_busy, .otp_read_data);
  unicor_host u_host (.ref_clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid);
  // ==========
  // checks and verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  function automatic logic [6:0] f_delay(input logic [3:0] code);
    return {code[3:1], 4'h8}; // odd multiple of eight bit times
  endfunction : f_delay
  task automatic end_sim;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_sim
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  // watchdog, run needs far fewer cycles
  initial begin
    #(3000 * 40);
    num_errors++;
    end_sim;
  end
  initial begin
    seed = 30;
    rst = 1'b1;
    {switch_node_comparator, step_source_select, encoder_index_config_pin, driver_disable_pin,
      encoder_a_config_pin, encoder_b_config_pin, right_ref_direction_input, left_ref_step_input} = 8'h00;
    address_increment_pin = 1'b0;
    uart_mode = 1'b0;
    actual_position = 32'h0;
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    chk(node_address, 32'h0, "node reset");
    chk(reply_delay_bit_times, 32'h8, "delay reset");
    chk(serial_out_config_pin, 32'h1, "polarity reset");
    chk(serial_out_config_oe, 32'h0, "enable reset");
    chk(otp_read_data, 32'h0, "otp port reset");
    $display("reset test done");
    // addresses 0, 253 and random, increment pin toggled
    for (int i = 0; i < 8; i++) begin
      a = (i == 0) ? 8'h00 : (i == 1) ? 8'hfd : 8'($unsigned($random(seed)) % 254);
      c = 4'(2 + $unsigned($random(seed)) % 14);
      address_increment_pin <= i[1];
      u_host.wr(7'h03, {20'h0, c, a});
      repeat (3) @(posedge ref_clk);
      #1;
      chk(node_address, a + 8'(i[1]), "node address");
      chk(reply_delay_bit_times, f_delay(c), "reply delay");
    end
    $display("address test done");
    for (int i = 0; i < 8; i++) begin
      p = (i == 0) ? 8'hff : 8'($random(seed));
      {switch_node_comparator, step_source_select, encoder_index_config_pin, driver_disable_pin,
        encoder_a_config_pin, encoder_b_config_pin, right_ref_direction_input, left_ref_step_input} <= p;
      u_host.rd(7'h04, d, ok);
      chk(ok, 32'h1, "read answer");
      chk(d, {VER, 16'h0, p}, "pin levels");
    end
    $display("pin test done");
    uart_mode <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      u_host.wr(7'h04, 32'(i));
      @(posedge ref_clk);
      #1;
      chk(serial_out_config_pin, 32'(i), "serial out level");
      chk(serial_out_config_oe, 32'h1, "serial out enable");
    end
    $display("polarity test done");
    v = $random(seed);
    u_host.wr(7'h05, v);
    for (int i = 0; i < 3; i++) begin
      actual_position <= v + 32'(i) - 32'h1;
      @(posedge ref_clk);
      @(posedge ref_clk);
      #1;
      chk(position_pulse_output_pin, 32'(i == 1), "position pulse");
    end
    $display("compare test done");
    ex = 32'h0;
    u_host.wr(7'h06, 32'h0000_4215); // wrong key
    #1;
    chk(otp_busy, 32'h0, "burn without key");
    for (int i = 0; i < 3; i++) begin
      b = 2'($random(seed));
      n = 3'($random(seed));
      u_host.wr(7'h06, {16'h0, 8'hbd, 2'h0, b, 1'b0, n});
      #1;
      chk(otp_busy, 32'h1, "burn start");
      u_host.wr(7'h06, {16'h0, 8'hbd, 2'h0, b, 1'b0, ~n}); // ignored while busy
      for (int k = 0; k < 20 && otp_busy; k++) @(posedge ref_clk);
      #1;
      chk(otp_busy, 32'h0, "burn end");
      ex = ex | (32'h1 << {b, n});
      u_host.rd(7'h06, d, ok);
      u_host.rd(7'h07, d, ok);
      chk(d, ex, "otp data");
      chk(otp_read_data, ex, "otp port");
    end
    $display("otp test done");
    end_sim;
  end
endmodule : uart_node_io_compare_otp_regs_tb
bind unicor_regs unicor_regs_chk #(.OTP_BIT_PROGRAM_CYCLES(OTP_BIT_PROGRAM_CYCLES), .VERSION_CODE(VERSION_CODE)) u_chk (
  .ref_clk, .rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid, .left_ref_step_input,
  .right_ref_direction_input, .encoder_b_config_pin, .encoder_a_config_pin, .driver_disable_pin,
  .encoder_index_config_pin, .step_source_select, .switch_node_comparator, .address_increment_pin,
  .actual_position, .node_address, .reply_delay_bit_times, .serial_out_config_pin, .position_pulse_output_pin,
  .otp_busy);

// ===== tb/unicor_host.sv
// host model: register writes and reads, answer capture
`timescale 1ns/1ps
`include "unicor_cfg.svh"
module unicor_host (
  input wire logic ref_clk,
  output logic reg_wr,
  output logic reg_rd,
  output logic [`UNICOR_ADDR_W-1:0] reg_addr,
  output logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata,
  input wire logic reg_rvalid
);
  logic [31:0] cap_r; // last answer
  logic got_r; // answer seen at last edge
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 7'h00;
    reg_wdata = 32'h0;
  end
  // answer stands one cycle, take it at its edge
  always @(posedge ref_clk) begin
    got_r <= reg_rvalid;
    cap_r <= reg_rdata;
  end
  task automatic wr(input logic [6:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d; // released data no longer shows the last word
  endtask : wr
  task automatic rd(input logic [6:0] a, output logic [31:0] d, output logic ok);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(posedge ref_clk);
    #1;
    d = cap_r;
    ok = got_r;
  endtask : rd
endmodule : unicor_host

// ===== tb/unicor_regs_chk.sv
// port checker of the register group
`timescale 1ns/1ps
`include "unicor_cfg.svh"
module unicor_regs_chk #(
  parameter int unsigned OTP_BIT_PROGRAM_CYCLES = 4,
  parameter logic [7:0] VERSION_CODE = 8'h5a // arbitrary
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [`UNICOR_ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic left_ref_step_input,
  input wire logic right_ref_direction_input,
  input wire logic encoder_b_config_pin,
  input wire logic encoder_a_config_pin,
  input wire logic driver_disable_pin,
  input wire logic encoder_index_config_pin,
  input wire logic step_source_select,
  input wire logic switch_node_comparator,
  input wire logic address_increment_pin,
  input wire logic [31:0] actual_position,
  input wire logic [7:0] node_address,
  input wire logic [`UNICOR_DELAY_W-1:0] reply_delay_bit_times,
  input wire logic serial_out_config_pin,
  input wire logic position_pulse_output_pin,
  input wire logic otp_busy
);
  // ==========
  // shadows of written values
  logic [31:0] cfg_q, cmp_q;
  logic [7:0] pins_q;
  logic pol_q, cmp_ok;
  logic [19:0] bcnt; // busy length, burn must end
  wire w3 = reg_wr && reg_addr == 7'h03;
  wire w4 = reg_wr && reg_addr == 7'h04;
  wire w5 = reg_wr && reg_addr == 7'h05;
  wire w6 = reg_wr && reg_addr == 7'h06;
  wire key = reg_wdata[15:8] == 8'hbd;
  // compare value unknown until first written
  wire match = cmp_ok && actual_position == cmp_q;
  // capture on the edges the design takes them
  always_ff @(posedge ref_clk) begin
    pins_q <= {switch_node_comparator, step_source_select, encoder_index_config_pin, driver_disable_pin,
      encoder_a_config_pin, encoder_b_config_pin, right_ref_direction_input, left_ref_step_input};
    if (w3) cfg_q <= reg_wdata;
    if (w4) pol_q <= reg_wdata[0];
    if (w5) cmp_q <= reg_wdata;
    cmp_ok <= !rst && (cmp_ok || w5);
    bcnt <= otp_busy ? bcnt + 20'h1 : 20'h0;
  end
  // ==========
  // properties
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence cfg_s(inc);
    w3 && address_increment_pin == inc ##1 (!w3 && address_increment_pin == inc)[*2];
  endsequence
  sequence pol_s;
    w4 ##1 !w4;
  endsequence
  node_plain_a: assert property (cfg_s(1'b0) |=> node_address == cfg_q[7:0])
    else $error("node address differs from write");
  node_incr_a: assert property (cfg_s(1'b1) |=> node_address == cfg_q[7:0] + 8'h01)
    else $error("node address not incremented");
  reply_delay_a: assert property (w3 ##1 !w3 [*2] |=> reply_delay_bit_times == {cfg_q[11:9], 4'h8})
    else $error("reply delay wrong");
  reset_vals_a: assert property ($fell(rst) |-> node_address == 8'h00 && serial_out_config_pin)
    else $error("reset values wrong");
  pin_read_a: assert property (reg_rd && reg_addr == 7'h04 |=> reg_rvalid && reg_rdata == {VERSION_CODE, 16'h0000, pins_q})
    else $error("pin level read wrong");
  polarity_a: assert property (pol_s |=> serial_out_config_pin == pol_q)
    else $error("serial out level wrong");
  pulse_a: assert property ($past(cmp_ok) |-> position_pulse_output_pin == $past(match))
    else $error("position pulse wrong");
  otp_start_a: assert property (w6 && key && !otp_busy |=> otp_busy)
    else $error("burn did not start");
  otp_key_a: assert property (w6 && !key && !otp_busy |=> !otp_busy)
    else $error("burn without key");
  otp_time_a: assert property (otp_busy |-> bcnt < OTP_BIT_PROGRAM_CYCLES)
    else $error("burn too long");
  burn_end_a: assert property (otp_busy && bcnt == 20'(OTP_BIT_PROGRAM_CYCLES - 1) |=> !otp_busy)
    else $error("burn did not end");
endmodule : unicor_regs_chk
